// ---- core/bcdp_pkg.sv ----
// Package with constants and types for the BCD point-table positioning sequencer.
package bcdp_pkg;

  // ---------------------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------------------
  localparam int CLK_PERIOD_NS   = 4;
  localparam int FILTER_UNIT_NS  = 1000;
  localparam int FILTER_UNIT_CYC = (FILTER_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FILTER_CNT_W    = 16;

  // ---------------------------------------------------------------------------
  // Setting fields of bcd_function_config
  // ---------------------------------------------------------------------------
  localparam int       OP_DIGIT_LSB     = 0;
  localparam int       SIGN_DIGIT_LSB   = 8;
  localparam int       STROBE_DIGIT_LSB = 12;
  localparam bit [3:0] OP_SYSTEM_BCD    = 4'h2;
  localparam bit [3:0] STROBE_USED      = 4'h0;
  localparam bit [3:0] SIGN_UNSIGNED    = 4'h0;
  localparam bit [3:0] SIGN_SIGNED      = 4'h1;

  // Command system and direction encodings.
  localparam bit CMD_ABSOLUTE = 1'b0;
  localparam bit CMD_INCREMENTAL = 1'b1;
  localparam bit DIR_NORMAL = 1'b0;

  // ---------------------------------------------------------------------------
  // Filtered input bit positions
  // ---------------------------------------------------------------------------
  localparam int IN_FWD    = 0;
  localparam int IN_REV    = 1;
  localparam int IN_SPEED  = 2;
  localparam int IN_PAUSE  = 6;
  localparam int IN_STROBE = 7;
  localparam int IN_SIGN   = 8;
  localparam int IN_DIGITS = 9;
  localparam int IN_COUNT  = 21;

  // ---------------------------------------------------------------------------
  // Reset profile and refused profile number
  // ---------------------------------------------------------------------------
  localparam bit [3:0] RST_PROFILE = 4'h0;
  localparam int       NO_PROFILE  = 0;

  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_MOVING = 2'b01,
    ST_PAUSED = 2'b10
  } bcdp_state_t;

endpackage : bcdp_pkg

// ---- core/bcdp_input_filter.sv ----
// Input filter: passes a new level only after it has stood for the set time.
`timescale 1ns/1ps
module bcdp_input_filter #(
  parameter int CNT_W = 16
) (
  input  wire logic             core_clk,
  input  wire logic             rstn,
  input  wire logic             rawIn,
  input  wire logic [CNT_W-1:0] filterCycles,
  output logic                  filtered
);

  logic [CNT_W-1:0] count;

  // ---------------------------------------------------------------------------
  // Stability counter
  // ---------------------------------------------------------------------------
  // A level differing from the output must hold filterCycles+1 edges.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      count    <= '0;
      filtered <= 1'b0;
    end else if (rawIn == filtered) begin
      count <= '0;
    end else if (count >= filterCycles) begin
      count    <= '0;
      filtered <= rawIn;
    end else begin
      count <= count + 1'b1;
    end
  end

endmodule : bcdp_input_filter

// ---- core/bcdp_sequencer.sv ----
// Automatic positioning sequencer: BCD position entry, profile select, start and pause.
//
// Contract
// - Forward start moves the given distance with the selected profile.
// - In incremental commanding, reverse start moves in the reverse direction.
// - Four speed select lines, highest first, form profile number 1 to 15.
// - In absolute commanding, reverse start is ignored.
// - Every external input is filtered for the set time before use; autoMode, homeJogActive and moveDone are used unfiltered.
// - Pause during automatic operation decelerates with the running profile.
// - Pause again while paused resumes and completes remaining distance.
// - Start inputs are ignored while a temporary stop is in effect.
// - Leaving automatic mode during a temporary stop discards remaining distance.
// - Pause is ignored during home return and jog motion.
// - Profile at the moment of start supplies acceleration and deceleration.
// - Position value arrives as three BCD digits transferred twice.
// - Operation digit must be 2 to enable BCD input.
// - Strobe digit 0 selects strobe use; controller drives the strobe.
// - Sign digit 0 gives unsigned six digits, 1 gives signed.
// - Command system 0 is absolute, 1 is incremental.
// - Direction 0: forward CCW, reverse CW; 1 swaps both.
`timescale 1ns/1ps
module bcdp_sequencer #(
  parameter int DIST_W = 21
) (
  input  wire logic              core_clk,
  input  wire logic              rstn,
  input  wire logic              forwardStart,
  input  wire logic              reverseStart,
  input  wire logic [3:0]        speedSelect,
  input  wire logic              pauseResume,
  input  wire logic              dataStrobe,
  input  wire logic              bcdSign,
  input  wire logic [11:0]       bcdDigits,
  input  wire logic              autoMode,
  input  wire logic              homeJogActive,
  input  wire logic              moveDone,
  input  wire logic [15:0]       bcdFunctionConfig,
  input  wire logic              commandSystemSetting,
  input  wire logic              directionSetting,
  input  wire logic [3:0]        inputFilterParam,
  output logic                   moveStart,
  output logic                   moveResume,
  output logic                   moveHold,
  output logic                   moveDiscard,
  output logic                   moveDirCw,
  output logic                   moveIncremental,
  output logic signed [DIST_W-1:0] moveDistance,
  output logic [3:0]             moveProfile,
  output logic                   busy,
  output logic                   positionValid
);

  // ---------------------------------------------------------------------------
  // Input filtering
  // ---------------------------------------------------------------------------
  logic [bcdp_pkg::IN_COUNT-1:0]     rawIn;
  logic [bcdp_pkg::IN_COUNT-1:0]     filt;
  logic [bcdp_pkg::IN_COUNT-1:0]     filtQ;
  logic [bcdp_pkg::FILTER_CNT_W-1:0] filterCycles;

  assign rawIn = {bcdDigits, bcdSign, dataStrobe, pauseResume, speedSelect,
                  reverseStart, forwardStart};
  assign filterCycles = bcdp_pkg::FILTER_CNT_W'(inputFilterParam *
                                                bcdp_pkg::FILTER_UNIT_CYC);

  genvar gi;
  generate
    for (gi = 0; gi < bcdp_pkg::IN_COUNT; gi++) begin : g_filt
      bcdp_input_filter #(
        .CNT_W (bcdp_pkg::FILTER_CNT_W)
      ) u_filt (
        .core_clk     (core_clk),
        .rstn         (rstn),
        .rawIn        (rawIn[gi]),
        .filterCycles (filterCycles),
        .filtered     (filt[gi])
      );
    end
  endgenerate

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      filtQ <= '0;
    end else begin
      filtQ <= filt;
    end
  end

  logic       fwdRise;
  logic       revRise;
  logic       pauseRise;
  logic       strobeRise;
  logic [3:0] profileSel;

  assign fwdRise    = filt[bcdp_pkg::IN_FWD] & ~filtQ[bcdp_pkg::IN_FWD];
  assign revRise    = filt[bcdp_pkg::IN_REV] & ~filtQ[bcdp_pkg::IN_REV];
  assign pauseRise  = filt[bcdp_pkg::IN_PAUSE] & ~filtQ[bcdp_pkg::IN_PAUSE];
  assign strobeRise = filt[bcdp_pkg::IN_STROBE] & ~filtQ[bcdp_pkg::IN_STROBE];
  assign profileSel = filt[bcdp_pkg::IN_SPEED +: 4];

  // ---------------------------------------------------------------------------
  // Settings decode
  // ---------------------------------------------------------------------------
  logic bcdEnabled;
  logic signedData;
  logic incremental;

  assign bcdEnabled =
    (bcdFunctionConfig[bcdp_pkg::OP_DIGIT_LSB +: 4] == bcdp_pkg::OP_SYSTEM_BCD) &&
    (bcdFunctionConfig[bcdp_pkg::STROBE_DIGIT_LSB +: 4] == bcdp_pkg::STROBE_USED);
  assign signedData =
    (bcdFunctionConfig[bcdp_pkg::SIGN_DIGIT_LSB +: 4] != bcdp_pkg::SIGN_UNSIGNED);
  assign incremental = (commandSystemSetting == bcdp_pkg::CMD_INCREMENTAL);

  // ---------------------------------------------------------------------------
  // BCD position capture
  // ---------------------------------------------------------------------------
  // Converts three BCD digits to binary.
  function automatic logic [9:0] bcd3(input logic [11:0] d);
    logic [9:0] v;
    v = 10'(d[11:8]) * 10'd100 + 10'(d[7:4]) * 10'd10 + 10'(d[3:0]);
    return v;
  endfunction : bcd3

  logic                     secondHalf;
  logic [9:0]               highPart;
  logic                     highSign;
  logic [19:0]              magnitude;
  logic signed [DIST_W-1:0] posValue;

  assign magnitude = 20'(highPart) * 20'd1000 +
                     20'(bcd3(filt[bcdp_pkg::IN_DIGITS +: 12]));

  // First strobe carries the upper digits and sign, the second the lower.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      secondHalf    <= 1'b0;
      highPart      <= '0;
      highSign      <= 1'b0;
      posValue      <= '0;
      positionValid <= 1'b0;
    end else if (!bcdEnabled) begin
      secondHalf    <= 1'b0;
      positionValid <= 1'b0;
    end else if (strobeRise) begin
      if (!secondHalf) begin
        highPart      <= bcd3(filt[bcdp_pkg::IN_DIGITS +: 12]);
        highSign      <= filt[bcdp_pkg::IN_SIGN];
        secondHalf    <= 1'b1;
        positionValid <= 1'b0;
      end else begin
        secondHalf    <= 1'b0;
        positionValid <= 1'b1;
        if (signedData && highSign) begin
          posValue <= -$signed(DIST_W'(magnitude));
        end else begin
          posValue <= $signed(DIST_W'(magnitude));
        end
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Sequencing state machine
  // ---------------------------------------------------------------------------
  bcdp_pkg::bcdp_state_t state;
  logic                  startOk;
  logic                  fwdGo;
  logic                  revGo;
  logic                  pauseOk;

  assign startOk = bcdEnabled && positionValid && autoMode && !homeJogActive &&
                   (profileSel != 4'(bcdp_pkg::NO_PROFILE));
  assign fwdGo   = startOk && fwdRise;
  assign revGo   = startOk && revRise && !fwdRise && incremental;
  assign pauseOk = pauseRise && autoMode && !homeJogActive;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      state <= bcdp_pkg::ST_IDLE;
    end else begin
      unique case (state)
        bcdp_pkg::ST_IDLE: begin
          if (fwdGo || revGo) begin
            state <= bcdp_pkg::ST_MOVING;
          end
        end
        bcdp_pkg::ST_MOVING: begin
          if (moveDone) begin
            state <= bcdp_pkg::ST_IDLE;
          end else if (pauseOk) begin
            state <= bcdp_pkg::ST_PAUSED;
          end
        end
        bcdp_pkg::ST_PAUSED: begin
          if (!autoMode) begin
            state <= bcdp_pkg::ST_IDLE;
          end else if (pauseOk) begin
            state <= bcdp_pkg::ST_MOVING;
          end
        end
        default: begin
          state <= bcdp_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------------------
  // Command outputs
  // ---------------------------------------------------------------------------
  logic inIdle;
  logic inMoving;
  logic inPaused;

  assign inIdle   = (state == bcdp_pkg::ST_IDLE);
  assign inMoving = (state == bcdp_pkg::ST_MOVING);
  assign inPaused = (state == bcdp_pkg::ST_PAUSED);

  // Starts are only taken from idle, so a paused move never restarts.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      moveStart       <= 1'b0;
      moveDirCw       <= 1'b0;
      moveIncremental <= 1'b0;
      moveDistance    <= '0;
      moveProfile     <= bcdp_pkg::RST_PROFILE;
    end else begin
      moveStart <= inIdle && (fwdGo || revGo);
      if (inIdle && (fwdGo || revGo)) begin
        moveProfile     <= profileSel;
        moveDistance    <= posValue;
        moveIncremental <= incremental;
        moveDirCw       <= fwdGo ? (directionSetting != bcdp_pkg::DIR_NORMAL)
                                 : (directionSetting == bcdp_pkg::DIR_NORMAL);
      end
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      moveHold    <= 1'b0;
      moveResume  <= 1'b0;
      moveDiscard <= 1'b0;
      busy        <= 1'b0;
    end else begin
      moveResume  <= inPaused && autoMode && pauseOk;
      moveDiscard <= inPaused && !autoMode;
      busy        <= (inIdle && (fwdGo || revGo)) ||
                     (inMoving && !moveDone) || (inPaused && autoMode);
      if (inMoving && !moveDone && pauseOk) begin
        moveHold <= 1'b1;
      end else if (inPaused && (!autoMode || pauseOk)) begin
        moveHold <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  property p_fwdStart;
    @(posedge core_clk) disable iff (!rstn)
    inIdle && fwdGo |=> moveStart && inMoving && busy;
  endproperty
  a_fwdStart: assert property (p_fwdStart) else $error("forward start not taken");

  property p_revInc;
    @(posedge core_clk) disable iff (!rstn)
    inIdle && revGo |=> moveStart && (moveDirCw == ($past(directionSetting) == 1'b0));
  endproperty
  a_revInc: assert property (p_revInc) else $error("reverse start direction wrong");

  property p_profile;
    @(posedge core_clk) disable iff (!rstn)
    inIdle && (fwdGo || revGo) |=> moveProfile == $past(filt[bcdp_pkg::IN_SPEED +: 4])
                                   && moveProfile != 4'h0;
  endproperty
  a_profile: assert property (p_profile) else $error("profile not captured");

  property p_absRev;
    @(posedge core_clk) disable iff (!rstn)
    inIdle && revRise && !fwdRise && !incremental |=>
      !moveStart ##1 (!moveStart || $past(fwdGo || revGo));
  endproperty
  a_absRev: assert property (p_absRev) else $error("reverse start acted in absolute");

  property p_pause;
    @(posedge core_clk) disable iff (!rstn)
    inMoving && !moveDone && pauseOk |=> moveHold && inPaused && !moveStart;
  endproperty
  a_pause: assert property (p_pause) else $error("pause not applied");

  property p_resume;
    @(posedge core_clk) disable iff (!rstn)
    inPaused && autoMode && pauseOk |=> moveResume && !moveHold ##1 !moveResume;
  endproperty
  a_resume: assert property (p_resume) else $error("resume not issued");

  property p_ignoreStart;
    @(posedge core_clk) disable iff (!rstn)
    inPaused && autoMode && !pauseOk |=> inPaused && !moveStart;
  endproperty
  a_ignoreStart: assert property (p_ignoreStart) else $error("start while paused");

  property p_discard;
    @(posedge core_clk) disable iff (!rstn)
    inPaused && !autoMode |=> moveDiscard && inIdle && !busy;
  endproperty
  a_discard: assert property (p_discard) else $error("remaining distance kept");

  property p_homeJog;
    @(posedge core_clk) disable iff (!rstn)
    homeJogActive && inMoving |=> !inPaused && !moveResume;
  endproperty
  a_homeJog: assert property (p_homeJog) else $error("pause acted in home or jog");

  property p_dirFwd;
    @(posedge core_clk) disable iff (!rstn)
    inIdle && fwdGo |=> moveDirCw == $past(directionSetting);
  endproperty
  a_dirFwd: assert property (p_dirFwd) else $error("forward direction wrong");

  property p_noRetrigger;
    @(posedge core_clk) disable iff (!rstn)
    moveStart |-> !$past(moveStart);
  endproperty
  a_noRetrigger: assert property (p_noRetrigger) else $error("start repeated");

  property p_disabled;
    @(posedge core_clk) disable iff (!rstn)
    !bcdEnabled |=> !positionValid;
  endproperty
  a_disabled: assert property (p_disabled) else $error("BCD valid while disabled");

  c_start: cover property (@(posedge core_clk) disable iff (!rstn) moveStart);
  c_pause: cover property (@(posedge core_clk) disable iff (!rstn) $rose(moveHold));
  c_resume: cover property (@(posedge core_clk) disable iff (!rstn) moveResume);
  c_discard: cover property (@(posedge core_clk) disable iff (!rstn) moveDiscard);

endmodule : bcdp_sequencer

// ---- verif/bcdp_ctrl_model.sv ----
// Behavioural programmable controller that drives the sequencer's filtered discrete inputs.
`timescale 1ns/1ps
module bcdp_ctrl_model (
  input  wire logic        core_clk,
  input  wire logic [3:0]  filterParam,
  output logic             forwardStart,
  output logic             reverseStart,
  output logic [3:0]       speedSelect,
  output logic             pauseResume,
  output logic             dataStrobe,
  output logic             bcdSign,
  output logic [11:0]      bcdDigits
);
  // ---------------------------------------------------------------------------
  // Output sequencing
  // ---------------------------------------------------------------------------
  initial begin
    forwardStart = 1'b0;
    reverseStart = 1'b0;
    speedSelect  = 4'h0;
    pauseResume  = 1'b0;
    dataStrobe   = 1'b0;
    bcdSign      = 1'b0;
    bcdDigits    = 12'h000;
  end

  // Every change but the closing scramble of send_half leads the next one by the filter time plus margin.
  task automatic lead_wait();
    repeat (filterParam * 250 + 3) @(posedge core_clk);
  endtask : lead_wait

  // One half of the value: data settle, then a strobe pulse, then the data are scrambled.
  task automatic send_half(input logic sign, input logic [11:0] digits);
    @(posedge core_clk);
    bcdSign   <= sign;
    bcdDigits <= digits;
    lead_wait();
    dataStrobe <= 1'b1;
    lead_wait();
    dataStrobe <= 1'b0;
    lead_wait();
    bcdDigits <= ~digits;
    bcdSign   <= ~sign;
  endtask : send_half

  task automatic press(input logic fwd, input logic [3:0] prof);
    @(posedge core_clk);
    speedSelect <= prof;
    lead_wait();
    if (fwd) forwardStart <= 1'b1;
    else reverseStart <= 1'b1;
  endtask : press

  task automatic release_start();
    @(posedge core_clk);
    forwardStart <= 1'b0;
    reverseStart <= 1'b0;
    lead_wait();
  endtask : release_start

  task automatic tap_pause();
    @(posedge core_clk);
    pauseResume <= 1'b1;
    lead_wait();
    pauseResume <= 1'b0;
    lead_wait();
  endtask : tap_pause
endmodule : bcdp_ctrl_model

// ---- verif/bcdp_sequencer_bench.sv ----
// Self-checking bench for the BCD positioning sequencer with a controller model.
`timescale 1ns/1ps
module bcdp_sequencer_bench;
  logic                     core_clk, rstn, forwardStart, reverseStart, pauseResume;
  logic                     dataStrobe, bcdSign, autoMode, homeJogActive, moveDone;
  logic [3:0]               speedSelect, inputFilterParam, moveProfile;
  logic [11:0]              bcdDigits;
  logic [15:0]              bcdFunctionConfig;
  logic                     commandSystemSetting, directionSetting, moveStart, moveResume;
  logic                     moveHold, moveDiscard, moveDirCw, moveIncremental, busy;
  logic                     positionValid;
  logic signed [20:0]       moveDistance;
  int                       err_count = 0;
  int                       num_checks = 0;
  int                       startCount = 0;
  int                       resumeCount = 0;
  int                       discardCount = 0;
  int                       cyc, snap;

  bcdp_sequencer #(.DIST_W(21)) bcdp_sequencer_inst (
    .core_clk(core_clk), .rstn(rstn), .forwardStart(forwardStart),
    .reverseStart(reverseStart), .speedSelect(speedSelect), .pauseResume(pauseResume),
    .dataStrobe(dataStrobe), .bcdSign(bcdSign), .bcdDigits(bcdDigits), .autoMode(autoMode),
    .homeJogActive(homeJogActive), .moveDone(moveDone), .bcdFunctionConfig(bcdFunctionConfig),
    .commandSystemSetting(commandSystemSetting), .directionSetting(directionSetting),
    .inputFilterParam(inputFilterParam), .moveStart(moveStart), .moveResume(moveResume),
    .moveHold(moveHold), .moveDiscard(moveDiscard), .moveDirCw(moveDirCw),
    .moveIncremental(moveIncremental), .moveDistance(moveDistance),
    .moveProfile(moveProfile), .busy(busy), .positionValid(positionValid));

  bcdp_ctrl_model bcdp_ctrl_model_inst (
    .core_clk(core_clk), .filterParam(inputFilterParam), .forwardStart(forwardStart),
    .reverseStart(reverseStart), .speedSelect(speedSelect), .pauseResume(pauseResume),
    .dataStrobe(dataStrobe), .bcdSign(bcdSign), .bcdDigits(bcdDigits));

  // ---------------------------------------------------------------------------
  // Clock, pulse counters and result handling
  // ---------------------------------------------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  always @(posedge core_clk) begin
    if (moveStart === 1'b1) startCount <= startCount + 1;
    if (moveResume === 1'b1) resumeCount <= resumeCount + 1;
    if (moveDiscard === 1'b1) discardCount <= discardCount + 1;
  end

  task automatic check_bit(input logic got, input logic exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check_bit

  task automatic check_val(input logic [20:0] got, input logic [20:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check_val

  task automatic tally_and_finish();
    $display("Checks made %0d, mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : tally_and_finish

  task automatic settle(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : settle

  task automatic wait_start();
    cyc = 0;
    do begin
      settle(1);
      cyc++;
    end while (moveStart !== 1'b1 && cyc < 2000);
    check_bit(moveStart, 1'b1);
  endtask : wait_start

  task automatic finish_move();
    @(posedge core_clk);
    moveDone <= 1'b1;
    @(posedge core_clk);
    moveDone <= 1'b0;
    settle(3);
    check_bit(busy, 1'b0);
  endtask : finish_move

  // A whole move; afterwards the start level stays high to show it does not fire again.
  task automatic move(input logic fwd, input logic [3:0] prof, input logic expCw,
                      input logic [20:0] expDist);
    bcdp_ctrl_model_inst.press(fwd, prof);
    wait_start();
    check_val(21'(moveProfile), 21'(prof));
    check_bit(moveDirCw, expCw);
    check_val(moveDistance, expDist);
    check_bit(moveIncremental, commandSystemSetting);
    finish_move();
    snap = startCount;
    settle(8);
    check_val(21'(startCount), 21'(snap));
    bcdp_ctrl_model_inst.release_start();
  endtask : move

  task automatic refused(input logic fwd, input logic [3:0] prof);
    snap = startCount;
    bcdp_ctrl_model_inst.press(fwd, prof);
    settle(10);
    check_val(21'(startCount), 21'(snap));
    bcdp_ctrl_model_inst.release_start();
  endtask : refused

  task automatic send_pos(input logic sign);
    bcdp_ctrl_model_inst.send_half(sign, 12'h123);
    check_bit(positionValid, 1'b0);
    bcdp_ctrl_model_inst.send_half(1'b0, 12'h456);
    check_bit(positionValid, 1'b1);
  endtask : send_pos

  // ---------------------------------------------------------------------------
  // Test sequence
  // ---------------------------------------------------------------------------
  initial begin
    rstn = 1'b0;
    autoMode = 1'b1;
    homeJogActive = 1'b0;
    moveDone = 1'b0;
    bcdFunctionConfig = 16'h0102;
    commandSystemSetting = 1'b0;
    directionSetting = 1'b0;
    inputFilterParam = 4'h0;
    repeat (20) @(posedge core_clk);
    rstn <= 1'b1;
    settle(1);
    check_bit(busy, 1'b0);
    check_bit(moveHold, 1'b0);
    $display("Test reset done");
    send_pos(1'b1);
    move(1'b1, 4'h5, 1'b0, -21'sd123456);
    for (int p = 1; p < 16; p++) move(1'b1, 4'(p), 1'b0, -21'sd123456);
    refused(1'b1, 4'h0);
    refused(1'b0, 4'h3);
    $display("Test profiles done");
    @(posedge core_clk);
    commandSystemSetting <= 1'b1;
    move(1'b0, 4'h2, 1'b1, -21'sd123456);
    @(posedge core_clk);
    directionSetting <= 1'b1;
    move(1'b1, 4'h4, 1'b1, -21'sd123456);
    move(1'b0, 4'h6, 1'b0, -21'sd123456);
    @(posedge core_clk);
    directionSetting <= 1'b0;
    bcdFunctionConfig <= 16'h0002;
    send_pos(1'b1);
    move(1'b1, 4'h8, 1'b0, 21'sd123456);
    $display("Test directions done");
    @(posedge core_clk);
    bcdFunctionConfig <= 16'h0001;
    settle(4);
    check_bit(positionValid, 1'b0);
    refused(1'b1, 4'h1);
    @(posedge core_clk);
    bcdFunctionConfig <= 16'h0102;
    send_pos(1'b0);
    bcdp_ctrl_model_inst.press(1'b1, 4'h7);
    wait_start();
    bcdp_ctrl_model_inst.release_start();
    bcdp_ctrl_model_inst.tap_pause();
    check_bit(moveHold, 1'b1);
    check_val(21'(moveProfile), 21'h7);
    refused(1'b1, 4'h9);
    snap = resumeCount;
    bcdp_ctrl_model_inst.tap_pause();
    check_val(21'(resumeCount), 21'(snap + 1));
    check_bit(moveHold, 1'b0);
    check_bit(busy, 1'b1);
    bcdp_ctrl_model_inst.tap_pause();
    snap = discardCount;
    @(posedge core_clk);
    autoMode <= 1'b0;
    settle(3);
    check_val(21'(discardCount), 21'(snap + 1));
    check_bit(busy, 1'b0);
    @(posedge core_clk);
    autoMode <= 1'b1;
    $display("Test pause done");
    bcdp_ctrl_model_inst.press(1'b1, 4'h3);
    wait_start();
    @(posedge core_clk);
    homeJogActive <= 1'b1;
    bcdp_ctrl_model_inst.tap_pause();
    check_bit(moveHold, 1'b0);
    @(posedge core_clk);
    homeJogActive <= 1'b0;
    finish_move();
    bcdp_ctrl_model_inst.release_start();
    @(posedge core_clk);
    inputFilterParam <= 4'h1;
    bcdp_ctrl_model_inst.press(1'b1, 4'h1);
    wait_start();
    check_val(21'(cyc), 21'(bcdp_pkg::FILTER_UNIT_CYC + 2));
    finish_move();
    bcdp_ctrl_model_inst.release_start();
    $display("Test filter and home done");
    tally_and_finish();
  end

  initial begin
    repeat (20000) @(posedge core_clk);
    err_count++;
    $display("ERROR t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
    tally_and_finish();
  end
endmodule : bcdp_sequencer_bench
